/* src/csr_pkg.sv */
// Summary of operation
// - straps 000/001/010/100 select 27, 32, 40.5 or 54 MHz line clock.
// - pll yields 40.5 MHz or 40 MHz working clock whatever line rate.
// - internal reset during power-on and on any supply undervoltage flag.
// - internal reset held until three good 5 MHz supervision periods seen.
// - while either reset is active the load-defaults and logic-reset outputs are held low.
// - internal reset stays active about 4 us after reset pin release.
// - then defaults are loaded; the load takes about 100 us.
// - horizontal drive goes high once standby supply is present.
// - with supervision clock valid, horizontal drive carries a 55 kHz pulse.
// - standby pulses persist until self-start enable is 1 while the sequence is in run.
package csr_pkg;
  localparam int CLK_MHZ        = 125;
  localparam int EXT_HOLD_US    = 4;
  localparam int EXT_HOLD_CYC   = EXT_HOLD_US * CLK_MHZ;
  localparam int LOAD_US        = 100;
  localparam int LOAD_CYC       = LOAD_US * CLK_MHZ;
  localparam int PLL_LOCK_US    = 500;
  localparam int SUP_CLK_KHZ    = 5000;
  localparam int SUP_PER_CYC    = CLK_MHZ * 1000 / SUP_CLK_KHZ;
  localparam int SUP_TOL_CYC    = 2;
  localparam int SUP_GOOD_CNT   = 3;
  localparam int HD_KHZ         = 55;
  localparam int HD_HALF_CYC    = CLK_MHZ * 1000 / (2 * HD_KHZ);
  localparam int CNT_W          = 16;
  localparam logic [2:0] SEL_27  = 3'h0;
  localparam logic [2:0] SEL_32  = 3'h1;
  localparam logic [2:0] SEL_405 = 3'h2;
  localparam logic [2:0] SEL_54  = 3'h4;
  typedef enum logic [2:0] {
    CSR_RATE_27  = 3'h0,
    CSR_RATE_32  = 3'h1,
    CSR_RATE_405 = 3'h2,
    CSR_RATE_54  = 3'h3,
    CSR_RATE_BAD = 3'h7
  } csr_rate_t;
  typedef enum logic [2:0] {
    CSR_POR   = 3'h0,
    CSR_HOLD  = 3'h1,
    CSR_LOAD  = 3'h3,
    CSR_RUN   = 3'h2
  } csr_state_t;
endpackage

/* src/csr_sync.sv */
`timescale 1ns/10ps
module csr_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

/* src/csr_clk_mon.sv */
`timescale 1ns/10ps
// judges the 5 MHz supervision clock by measuring its rising-edge period
module csr_clk_mon
  import csr_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic sup_clk_s_i,
  output logic      valid_o
);
  logic       prev;
  logic [7:0] per;
  logic [1:0] good;
  logic       next_prev;
  logic [7:0] next_per;
  logic [1:0] next_good;
  logic       next_valid;
  logic       rise;
  logic       in_tol;
  always_comb begin
    rise       = sup_clk_s_i & ~prev;
    in_tol     = (per >= 8'(SUP_PER_CYC - SUP_TOL_CYC)) && (per <= 8'(SUP_PER_CYC + SUP_TOL_CYC));
    next_prev  = sup_clk_s_i;
    next_per   = (per == 8'hFF) ? per : per + 8'h01;
    next_good  = good;
    next_valid = valid_o;
    if (per == 8'hFF) begin
      // clock stopped: drop validity so reset is reasserted
      next_good  = 2'h0;
      next_valid = 1'b0;
    end
    if (rise) begin
      next_per = 8'h01;
      if (in_tol) begin
        if (good == 2'(SUP_GOOD_CNT - 1))
          next_valid = 1'b1;
        else
          next_good = good + 2'h1;
      end else begin
        next_good  = 2'h0;
        next_valid = 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev    <= 1'b0;
      per     <= 8'h00;
      good    <= 2'h0;
      valid_o <= 1'b0;
    end else begin
      prev    <= next_prev;
      per     <= next_per;
      good    <= next_good;
      valid_o <= next_valid;
    end
  end
endmodule

/* src/csr_top.sv */
`timescale 1ns/10ps
// reset and start-up sequencer; outputs are registered
module csr_top
  import csr_pkg::*;
#(
  parameter int HOLD_CYC = EXT_HOLD_CYC,
  parameter int LOAD_CYCLES = LOAD_CYC
) (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       external_reset_n_i,
  input  wire logic       standby_supply_ok_i,
  input  wire logic       digital_supply_ok_i,
  input  wire logic       output_supply_ok_i,
  input  wire logic       sup_clk_i,
  input  wire logic       stream_input_enable_i,
  input  wire logic       clock_select_hi_i,
  input  wire logic       clock_select_lo_i,
  input  wire logic       self_start_en_i,
  output logic [2:0]      line_rate_o,
  output logic            work_clk_40_o,
  output logic            strap_bad_o,
  output logic            internal_reset_o,
  output logic            load_defaults_o,
  output logic            logic_rst_n_o,
  output logic            sup_clk_valid_o,
  output logic            horizontal_drive_out_o,
  output logic            self_start_o
);
  logic [6:0] pins_s;
  logic       ext_n_s;
  logic       stby_s;
  logic       supd_s;
  logic       supo_s;
  logic       sclk_s;
  logic [2:0] straps_s;
  logic       sup_valid;

  csr_sync #(.W(7)) u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .d_i        ({external_reset_n_i, standby_supply_ok_i, digital_supply_ok_i, output_supply_ok_i,
                  stream_input_enable_i, clock_select_hi_i, clock_select_lo_i}),
    .q_o        (pins_s)
  );
  assign {ext_n_s, stby_s, supd_s, supo_s, straps_s} = pins_s;

  csr_sync #(.W(1)) u_sync_clk (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .d_i        (sup_clk_i),
    .q_o        (sclk_s)
  );

  csr_clk_mon u_mon (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .sup_clk_s_i (sclk_s),
    .valid_o     (sup_valid)
  );

  function automatic csr_rate_t decode_rate(input logic [2:0] s);
    case (s)
      SEL_27:  decode_rate = CSR_RATE_27;
      SEL_32:  decode_rate = CSR_RATE_32;
      SEL_405: decode_rate = CSR_RATE_405;
      SEL_54:  decode_rate = CSR_RATE_54;
      default: decode_rate = CSR_RATE_BAD;
    endcase
  endfunction

  // strap decode and derived working clock choice
  csr_rate_t  rate;
  logic [2:0] next_line_rate;
  logic       next_work_40;
  logic       next_strap_bad;
  always_comb begin
    rate           = decode_rate(straps_s);
    next_line_rate = 3'(rate);
    next_strap_bad = (rate == CSR_RATE_BAD);
    // 32 MHz line clock gives a 40 MHz working clock, all others 40.5 MHz
    next_work_40   = (rate == CSR_RATE_32);
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_rate_o   <= 3'h0;
      work_clk_40_o <= 1'b0;
      strap_bad_o   <= 1'b0;
    end else begin
      line_rate_o   <= next_line_rate;
      work_clk_40_o <= next_work_40;
      strap_bad_o   <= next_strap_bad;
    end
  end

  // reset sequence
  csr_state_t       state;
  csr_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             int_rst;
  logic             next_int_reset;
  logic             next_load;
  logic             next_logic_rst_n;
  logic             next_sup_valid;
  always_comb begin
    int_rst          = ~stby_s | ~supd_s | ~supo_s | ~sup_valid;
    next_state       = state;
    next_cnt         = cnt;
    case (state)
      CSR_POR: begin
        next_cnt = '0;
        if (!int_rst && ext_n_s) begin
          next_state = CSR_HOLD;
        end
      end
      CSR_HOLD: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(HOLD_CYC - 1)) begin
          next_state = CSR_LOAD;
          next_cnt   = '0;
        end
      end
      CSR_LOAD: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(LOAD_CYCLES - 1)) begin
          next_state = CSR_RUN;
          next_cnt   = '0;
        end
      end
      CSR_RUN: next_cnt = '0;
      default: begin
        next_state = CSR_POR;
        next_cnt   = '0;
      end
    endcase
    if (int_rst || !ext_n_s) begin
      // any reset source clears the sequence back to zero
      next_state = CSR_POR;
      next_cnt   = '0;
    end
    next_int_reset   = (next_state == CSR_POR) || (next_state == CSR_HOLD);
    next_load        = (next_state == CSR_LOAD);
    next_logic_rst_n = (next_state == CSR_RUN);
    next_sup_valid   = sup_valid;
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state            <= CSR_POR;
      cnt              <= '0;
      internal_reset_o <= 1'b1;
      load_defaults_o  <= 1'b0;
      logic_rst_n_o    <= 1'b0;
      sup_clk_valid_o  <= 1'b0;
    end else begin
      state            <= next_state;
      cnt              <= next_cnt;
      internal_reset_o <= next_int_reset;
      load_defaults_o  <= next_load;
      logic_rst_n_o    <= next_logic_rst_n;
      sup_clk_valid_o  <= next_sup_valid;
    end
  end

  // horizontal drive: high on standby, 55 kHz once supervised clock valid, until self-start
  // the 1136-cycle half period needs eleven bits; ten would wrap early
  logic [10:0] hcnt;
  logic [10:0] next_hcnt;
  logic       next_hd;
  logic       next_self_start;
  always_comb begin
    next_hcnt       = '0;
    next_hd         = 1'b0;
    next_self_start = self_start_o;
    if (state == CSR_RUN && self_start_en_i) begin
      next_self_start = 1'b1;
    end
    if (!stby_s) begin
      next_self_start = 1'b0;
    end else if (next_self_start) begin
      // self-start logic elsewhere takes over the drive
      next_hd = 1'b0;
    end else if (!sup_valid) begin
      next_hd = 1'b1;
    end else begin
      next_hd   = horizontal_drive_out_o;
      next_hcnt = hcnt + 11'h001;
      if (hcnt == 11'(HD_HALF_CYC - 1)) begin
        next_hcnt = '0;
        next_hd   = ~horizontal_drive_out_o;
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hcnt                   <= '0;
      horizontal_drive_out_o <= 1'b0;
      self_start_o           <= 1'b0;
    end else begin
      hcnt                   <= next_hcnt;
      horizontal_drive_out_o <= next_hd;
      self_start_o           <= next_self_start;
    end
  end
endmodule

/* tb/csr_sva.sv */
`timescale 1ns/10ps
module csr_chk
  import csr_pkg::*;
#(
  parameter int HOLD_CYC    = 4,
  parameter int LOAD_CYCLES = 8
) (
  input wire logic       core_clk_i,
  input wire logic       rstn_i,
  input wire logic       external_reset_n_i,
  input wire logic       standby_supply_ok_i,
  input wire logic       digital_supply_ok_i,
  input wire logic       output_supply_ok_i,
  input wire logic       stream_input_enable_i,
  input wire logic       clock_select_hi_i,
  input wire logic       clock_select_lo_i,
  input wire logic       self_start_en_i,
  input wire logic [2:0] line_rate_o,
  input wire logic       work_clk_40_o,
  input wire logic       strap_bad_o,
  input wire logic       internal_reset_o,
  input wire logic       load_defaults_o,
  input wire logic       logic_rst_n_o,
  input wire logic       sup_clk_valid_o,
  input wire logic       horizontal_drive_out_o,
  input wire logic       self_start_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [2:0]  strap;
  logic [15:0] ok_cnt;
  logic [15:0] ld_cnt;
  logic [15:0] hd_cnt;
  logic        tog;
  logic        ok;
  assign strap = {stream_input_enable_i, clock_select_hi_i, clock_select_lo_i};
  assign ok = external_reset_n_i && standby_supply_ok_i && digital_supply_ok_i && output_supply_ok_i && sup_clk_valid_o;
  // tog marks that the previous drive edge came from the free-running pulse train
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ok_cnt <= '0;
      ld_cnt <= '0;
      hd_cnt <= '0;
      tog    <= 1'b0;
    end else begin
      ok_cnt <= ok ? ok_cnt + 16'h1 : '0;
      ld_cnt <= load_defaults_o ? ld_cnt + 16'h1 : '0;
      hd_cnt <= $changed(horizontal_drive_out_o) ? '0 : hd_cnt + 16'h1;
      tog    <= (sup_clk_valid_o && !self_start_o && standby_supply_ok_i)
                && ($changed(horizontal_drive_out_o) || tog);
    end
  end
  property p_rate;
    $stable(strap)[*4] |-> line_rate_o == ((strap == 3'h4) ? 3'h3 : (strap > 3'h2) ? 3'h7 : strap)
      && strap_bad_o == (line_rate_o == 3'h7) && work_clk_40_o == (strap == 3'h1);
  endproperty
  property p_src;
    $fell(standby_supply_ok_i && digital_supply_ok_i && output_supply_ok_i) || $fell(external_reset_n_i)
      |-> ##[1:5] internal_reset_o;
  endproperty
  property p_zero;
    internal_reset_o |-> !load_defaults_o && !logic_rst_n_o;
  endproperty
  property p_hold;
    $fell(internal_reset_o) |-> ok_cnt >= HOLD_CYC - 1 && ok_cnt <= HOLD_CYC + 6;
  endproperty
  property p_load;
    $rose(logic_rst_n_o) |-> $past(load_defaults_o) && ld_cnt >= LOAD_CYCLES && ld_cnt <= LOAD_CYCLES + 1;
  endproperty
  property p_valid;
    $fell(internal_reset_o) |-> sup_clk_valid_o;
  endproperty
  property p_hd_hi;
    (standby_supply_ok_i && !sup_clk_valid_o && !self_start_o)[*5] |-> horizontal_drive_out_o;
  endproperty
  property p_hd_per;
    $changed(horizontal_drive_out_o) && tog && sup_clk_valid_o && !self_start_o |-> hd_cnt == HD_HALF_CYC - 1;
  endproperty
  property p_ss;
    (self_start_en_i && logic_rst_n_o)[*4] |-> self_start_o;
  endproperty
  property p_ss_hd;
    self_start_o[*3] |-> !horizontal_drive_out_o;
  endproperty
  a_rate: assert property (p_rate) else $error("strap decode wrong");
  a_src: assert property (p_src) else $error("reset source ignored");
  a_zero: assert property (p_zero) else $error("state not cleared in reset");
  a_hold: assert property (p_hold) else $error("hold time wrong");
  a_load: assert property (p_load) else $error("default load length wrong");
  a_valid: assert property (p_valid) else $error("reset left without valid clock");
  a_hd_hi: assert property (p_hd_hi) else $error("drive not high on standby");
  a_hd_per: assert property (p_hd_per) else $error("drive half period wrong");
  a_ss: assert property (p_ss) else $error("self start not taken");
  a_ss_hd: assert property (p_ss_hd) else $error("drive active after self start");
  c_run: cover property ($rose(logic_rst_n_o));
  c_tog: cover property ($changed(horizontal_drive_out_o) && tog);
  c_ss: cover property ($rose(self_start_o));
endmodule

bind csr_top csr_chk #(.HOLD_CYC(HOLD_CYC), .LOAD_CYCLES(LOAD_CYCLES)) i_chk (.*);

/* tb/csr_partner.sv */
`timescale 1ns/10ps
module csr_partner #(
  parameter int PIN_HOLD_NS = 404
) (
  input  wire logic       run_i,
  input  wire logic [7:0] half_ns_i,
  input  wire logic       pin_req_i,
  output logic            sup_clk_o,
  output logic            external_reset_n_o
);
  // a stopped supervision clock stands still, as a dead oscillator would
  initial begin
    sup_clk_o = 1'b0;
    forever begin
      wait (run_i);
      #(half_ns_i) sup_clk_o = ~sup_clk_o;
    end
  end
  // scaled stand-in for the pll lock wait before the pin may rise
  initial begin
    external_reset_n_o = 1'b0;
    forever begin
      wait (pin_req_i);
      #(PIN_HOLD_NS) external_reset_n_o = pin_req_i;
      wait (!pin_req_i);
      external_reset_n_o = 1'b0;
    end
  end
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
module tb;
  import csr_pkg::*;
  logic        core_clk_i, rstn_i, stby, dig, outs, sie, hi, lo, en, run, req;
  logic        ext_n, sup_clk, w40, bad, irst, load, lrst_n, valid, hd, ss;
  logic [2:0]  rate, st;
  logic [7:0]  half;
  logic [31:0] lfsr;
  int          fail_count, comparisons, n;
  csr_partner i_prt (.run_i(run), .half_ns_i(half), .pin_req_i(req), .sup_clk_o(sup_clk), .external_reset_n_o(ext_n));
  csr_top #(.HOLD_CYC(4), .LOAD_CYCLES(8)) i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .external_reset_n_i(ext_n), .standby_supply_ok_i(stby), .digital_supply_ok_i(dig), .output_supply_ok_i(outs),
    .sup_clk_i(sup_clk), .stream_input_enable_i(sie), .clock_select_hi_i(hi), .clock_select_lo_i(lo),
    .self_start_en_i(en), .line_rate_o(rate), .work_clk_40_o(w40), .strap_bad_o(bad), .internal_reset_o(irst),
    .load_defaults_o(load), .logic_rst_n_o(lrst_n), .sup_clk_valid_o(valid), .horizontal_drive_out_o(hd),
    .self_start_o(ss));
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [2:0] exp_rate(logic [2:0] s);
    return (s == 3'h4) ? 3'h3 : (s > 3'h2) ? 3'h7 : s;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wait_chg(ref logic s, input int lim);
    logic v;
    v = s;
    n = 0;
    while (s === v && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic print_verdict;
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial begin
    #160000;
    fail_count++;
    print_verdict();
  end
  initial begin
    {rstn_i, stby, dig, outs, sie, hi, lo, en, run, req} = '0;
    half = 8'h64;
    lfsr = 32'h507DF838;
    fail_count = 0;
    comparisons = 0;
    tick(20);
    rstn_i = 1'b1;
    stby = 1'b1;
    // supervision clock starts early so the pin release is the last start condition
    run = 1'b1;
    en = 1'b1;
    tick(8);
    check(16'(hd), 16'h1);
    check(16'(ss), 16'h0);
    en = 1'b0;
    for (int i = 0; i < 14; i++) begin
      lfsr = nxt(lfsr);
      st = (i < 8) ? i[2:0] : lfsr[2:0];
      {sie, hi, lo} = st;
      tick(5);
      check(16'({bad, w40, rate}), 16'({exp_rate(st) == 3'h7, st == 3'h1, exp_rate(st)}));
    end
    {dig, outs, req} = 3'h7;
    wait_chg(ext_n, 300);
    wait_chg(load, 100);
    check(16'(n >= 5 && n <= 11), 16'h1);
    wait_chg(lrst_n, 100);
    check(16'(n >= 8 && n <= 9), 16'h1);
    check(16'({valid, irst}), 16'h2);
    wait_chg(hd, 2400);
    wait_chg(hd, 2400);
    check(16'(n), 16'(HD_HALF_CYC));
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      case (i)
        0: {stby, dig, outs} = {2'h3, 1'b0} << (lfsr[0] ? 1 : 0);
        1: half = 8'h3C;
        default: req = 1'b0;
      endcase
      tick(lfsr[3:0] + 60);
      check(16'({irst, load, lrst_n}), 16'h4);
      {stby, dig, outs, req} = 4'hF;
      half = 8'h64;
      wait_chg(lrst_n, 1000);
      check(16'(lrst_n), 16'h1);
    end
    en = 1'b1;
    tick(8);
    check(16'({ss, hd}), 16'h2);
    print_verdict();
  end
endmodule
